// ---- logic/byte_alu.sv ----
// Purpose: computes the memory result for or and rotate-left
// Assumes: operands held stable by the caller
// Notes: zero is reported for every result; the caller decides who keeps it
`timescale 1ns/10ps
module byte_alu
    import exec_pkg::*;
(
    alu_if.alu bus
);
    // result selection; other ops pass memory through untouched
    always_comb begin
        unique case (bus.op)
            OP_OR_TO_MEMORY: bus.result = bus.acc | bus.mem;
            OP_ROTATE_LEFT_MEMORY: bus.result = {bus.mem[MSB_POS-1:LSB_POS], bus.mem[MSB_POS]};
            default: bus.result = bus.mem;
        endcase
        bus.zero = (bus.result == '0);
    end
endmodule : byte_alu

// ---- logic/return_or_rotate_exec.sv ----
// Purpose: executes or-to-memory, rotate-left-memory and the three return forms
// Assumes: the stack top and memory read data are valid while exec_valid_in is high
// Notes: one instruction at a time; a new request is ignored while busy_out is high
//        memory operands arrive already read; this unit only issues the write-back
//        an interrupt return with a request pending leaves its return address on the stack,
//        so the service routine's own return resumes the interrupted program
//        every port is a flop, so downstream logic sees no decode glitches
`timescale 1ns/10ps
module return_or_rotate_exec
    import exec_pkg::*;
#(
    parameter logic [PC_W-1:0] IRQ_VECTOR = IRQ_VECTOR_DEFAULT
)(
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // instruction request
    input wire logic exec_valid_in,
    input wire logic [2:0] exec_op_in,
    input wire logic [ADDR_W-1:0] mem_addr_in,
    input wire logic [DATA_W-1:0] literal_in,
    input wire logic [DATA_W-1:0] mem_rdata_in,
    input wire logic [PC_W-1:0] stack_top_in,
    input wire logic irq_pending_in,
    // memory write port
    output logic mem_we_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic [DATA_W-1:0] mem_wdata_out,
    // stack and program flow
    output logic stack_pop_out,
    output logic pc_load_out,
    output logic [PC_W-1:0] pc_out,
    output logic irq_ack_out,
    // architectural state
    output logic [DATA_W-1:0] working_accumulator_out,
    output logic zero_flag_out,
    output logic master_interrupt_enable_out,
    output logic busy_out
);
    exec_state_t state_reg;
    exec_op_t op_in;
    logic [DATA_W-1:0] acc_reg;
    logic zero_reg;
    logic emi_reg;
    logic [PC_W-1:0] vec_pc_reg;
    // request strobes, one per class of taken instruction
    logic take;
    logic take_mem;
    logic take_sub_ret;
    logic take_interrupt_return_plain;
    logic take_interrupt_return_pending;
    logic busy_reg;
    alu_if alu_bus ();

    // op class decode, used only by the take_mem and take_sub_ret strobes
    function automatic logic is_mem_op(input exec_op_t op);
        return (op == OP_OR_TO_MEMORY) || (op == OP_ROTATE_LEFT_MEMORY);
    endfunction : is_mem_op

    // plain and literal returns pop the stack the same way
    function automatic logic is_sub_return(input exec_op_t op);
        return (op == OP_SUBROUTINE_RETURN) || (op == OP_RETURN_WITH_LITERAL);
    endfunction : is_sub_return

    assign op_in = exec_op_t'(exec_op_in);
    assign take = exec_valid_in && (state_reg == ST_IDLE);
    // one strobe per class of taken request; the zero, accumulator and enable processes decode take and op_in directly
    assign take_mem = take && is_mem_op(op_in);
    assign take_sub_ret = take && is_sub_return(op_in);
    assign take_interrupt_return_plain = take && (op_in == OP_INTERRUPT_RETURN) && !irq_pending_in;
    assign take_interrupt_return_pending = take && (op_in == OP_INTERRUPT_RETURN) && irq_pending_in;
    // the alu works on the accumulator and the byte offered with the current request
    assign alu_bus.acc = acc_reg;
    assign alu_bus.mem = mem_rdata_in;
    assign alu_bus.op = op_in;

    // purely combinational; its result is captured only when a memory op is taken
    byte_alu u_alu (
        .bus(alu_bus)
    );

    // sequencer: memory ops write one cycle later, interrupt return may add a vector cycle
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (take_mem) begin
                        state_reg <= ST_WRITE;
                    end else if (take_interrupt_return_pending) begin
                        state_reg <= ST_VECTOR;
                    end
                end
                ST_WRITE: state_reg <= ST_IDLE;
                ST_VECTOR: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // busy kept as a flop of its own so the port is registered; it tracks the sequencer's
    // next state, which leaves idle only for a memory op or a pending interrupt return
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            busy_reg <= 1'b0;
        end else if (take_mem || take_interrupt_return_pending) begin
            busy_reg <= 1'b1;
        end else begin
            busy_reg <= 1'b0;
        end
    end

    // memory write-back of the alu result
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            mem_we_out <= 1'b0;
            mem_addr_out <= '0;
            mem_wdata_out <= '0;
        end else begin
            mem_we_out <= 1'b0;
            if (take_mem) begin
                mem_we_out <= 1'b1;
                mem_addr_out <= mem_addr_in;
                mem_wdata_out <= alu_bus.result;
            end
        end
    end

    // zero flag: only or-to-memory touches it, rotate and returns leave it alone
    // a rotate whose result happens to be zero must not disturb it either
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            zero_reg <= 1'b0;
        end else if (take && op_in == OP_OR_TO_MEMORY) begin
            zero_reg <= alu_bus.zero;
        end
    end

    // accumulator: only the literal return writes it
    // or-to-memory reads it but leaves it as it was
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            acc_reg <= ACC_RESET;
        end else if (take && op_in == OP_RETURN_WITH_LITERAL) begin
            acc_reg <= literal_in;
        end
    end

    // master enable set by interrupt return; cleared again in the vector cycle after a pending one is taken,
    // as any interrupt entry would, so the vector runs with interrupts masked
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            emi_reg <= 1'b0;
        end else if (take && op_in == OP_INTERRUPT_RETURN && !irq_pending_in) begin
            emi_reg <= 1'b1;
        end else if (state_reg == ST_VECTOR) begin
            emi_reg <= 1'b0;
        end else if (take && op_in == OP_INTERRUPT_RETURN) begin
            emi_reg <= 1'b1;
        end
    end

    // stack pop: every return form pops except an interrupt return with a request pending,
    // whose return address stays on the stack for the service routine's own return
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            stack_pop_out <= 1'b0;
        end else begin
            stack_pop_out <= take_sub_ret || take_interrupt_return_plain;
        end
    end

    // vector address captured when the pending case is taken, used one cycle later
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            vec_pc_reg <= PC_RESET;
        end else if (take_interrupt_return_pending) begin
            vec_pc_reg <= IRQ_VECTOR;
        end
    end

    // program counter load: the popped address, or the vector in the extra cycle
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pc_load_out <= 1'b0;
            pc_out <= PC_RESET;
        end else begin
            pc_load_out <= 1'b0;
            if (take_sub_ret || take_interrupt_return_plain) begin
                pc_load_out <= 1'b1;
                pc_out <= stack_top_in;
            end else if (state_reg == ST_VECTOR) begin
                pc_load_out <= 1'b1;
                pc_out <= vec_pc_reg;
            end
        end
    end

    // acknowledge goes out with the vector load so the requester can drop its pending level
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            irq_ack_out <= 1'b0;
        end else begin
            irq_ack_out <= (state_reg == ST_VECTOR);
        end
    end

    // ports straight from their flops
    assign working_accumulator_out = acc_reg;
    assign zero_flag_out = zero_reg;
    assign master_interrupt_enable_out = emi_reg;
    assign busy_out = busy_reg;
endmodule : return_or_rotate_exec

// ---- pkg/alu_if.sv ----
// Purpose: carries operands and result between the sequencer and the byte alu
// Assumes: purely combinational alu
// Notes: none
`timescale 1ns/10ps
interface alu_if;
    import exec_pkg::*;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] mem;
    exec_op_t op;
    logic [DATA_W-1:0] result;
    logic zero;
    modport user (output acc, output mem, output op, input result, input zero);
    modport alu (input acc, input mem, input op, output result, output zero);
endinterface : alu_if

// ---- pkg/exec_pkg.sv ----
// Purpose: shared constants and types for the return/rotate/or execution slice
// Assumes: 8-bit data path, one instruction issued per request pulse
// Notes: opcode codes and widths below are local choices for this slice
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PC_W = 13;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR_DEFAULT = 13'h0004;
    localparam int MSB_POS = 7;
    localparam int LSB_POS = 0;

    // instruction selector driven by the decoder in front of this unit
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_OR_TO_MEMORY = 3'b001,
        OP_SUBROUTINE_RETURN = 3'b010,
        OP_RETURN_WITH_LITERAL = 3'b011,
        OP_INTERRUPT_RETURN = 3'b100,
        OP_ROTATE_LEFT_MEMORY = 3'b101
    } exec_op_t;

    // execution sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_VECTOR = 2'b10
    } exec_state_t;
endpackage : exec_pkg

// ---- tb/exec_assertions.sv ----
// Purpose: port-level checks of the return/or/rotate unit
// Assumes: one request taken per edge with busy low
// Notes: results are tied to operands one cycle back
`timescale 1ns/10ps
module exec_check #(
    parameter logic [12:0] IRQ_VECTOR = 13'h0004
)(
    // clock, reset and request
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic exec_valid_in,
    input wire logic [2:0] exec_op_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [7:0] literal_in,
    input wire logic [12:0] stack_top_in,
    input wire logic irq_pending_in,
    // outputs watched
    input wire logic mem_we_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic stack_pop_out,
    input wire logic pc_load_out,
    input wire logic [12:0] pc_out,
    input wire logic irq_ack_out,
    input wire logic [7:0] working_accumulator_out,
    input wire logic zero_flag_out,
    input wire logic master_interrupt_enable_out,
    input wire logic busy_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // a request counts only when the unit is idle
    wire take = exec_valid_in && !busy_out;
    // one check per documented behaviour
    a_or_write: assert property (take && exec_op_in == 3'h1 |=> mem_we_out &&
        mem_wdata_out == ($past(working_accumulator_out) | $past(mem_rdata_in))) else $error("or result wrong");
    a_zero_track: assert property (take && exec_op_in == 3'h1 |=>
        zero_flag_out == (mem_wdata_out == 8'h00)) else $error("zero flag wrong");
    a_rot_write: assert property (take && exec_op_in == 3'h5 |=> mem_we_out && $stable(zero_flag_out) &&
        mem_wdata_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])}) else $error("rotate wrong");
    a_ret_pop: assert property (take && exec_op_in == 3'h2 |=> stack_pop_out && pc_load_out &&
        pc_out == $past(stack_top_in) && $stable(zero_flag_out)) else $error("return wrong");
    a_lit_load: assert property (take && exec_op_in == 3'h3 |=> stack_pop_out &&
        working_accumulator_out == $past(literal_in) && $stable(zero_flag_out)) else $error("literal wrong");
    a_interrupt_return_enable: assert property (take && exec_op_in == 3'h4 |=> master_interrupt_enable_out &&
        $stable(zero_flag_out)) else $error("enable not set");
    a_interrupt_return_plain: assert property (take && exec_op_in == 3'h4 && !irq_pending_in |=> stack_pop_out &&
        pc_out == $past(stack_top_in)) else $error("interrupt return wrong");
    a_interrupt_return_vector: assert property (take && exec_op_in == 3'h4 && irq_pending_in |=> !pc_load_out ##1
        pc_load_out && irq_ack_out && !stack_pop_out && pc_out == IRQ_VECTOR) else $error("vector wrong");
    a_vector_masked: assert property (irq_ack_out |->
        !master_interrupt_enable_out) else $error("interrupt entry left enable set");
    // main scenarios reached
    c_write: cover property (mem_we_out);
    c_vector: cover property (irq_ack_out);
    c_return: cover property (stack_pop_out && pc_load_out);
endmodule : exec_check
bind return_or_rotate_exec exec_check #(.IRQ_VECTOR(IRQ_VECTOR)) chk_u (.clock_in(clock_in),
    .resetn_in(resetn_in), .exec_valid_in(exec_valid_in), .exec_op_in(exec_op_in), .mem_rdata_in(mem_rdata_in),
    .literal_in(literal_in), .stack_top_in(stack_top_in), .irq_pending_in(irq_pending_in),
    .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .stack_pop_out(stack_pop_out),
    .pc_load_out(pc_load_out), .pc_out(pc_out), .irq_ack_out(irq_ack_out),
    .working_accumulator_out(working_accumulator_out), .zero_flag_out(zero_flag_out),
    .master_interrupt_enable_out(master_interrupt_enable_out), .busy_out(busy_out));

// ---- tb/testbench.sv ----
// Purpose: directed scenarios for the return/or/rotate unit
// Assumes: outputs settle one cycle after a taken request
// Notes: accumulator is set through the literal return
`timescale 1ns/10ps
module testbench;
    import exec_pkg::*;
    logic clock_in, resetn_in, exec_valid_in, irq_pending_in;
    logic [2:0] exec_op_in;
    logic [7:0] mem_addr_in, literal_in, mem_rdata_in, mem_addr_out, mem_wdata_out, working_accumulator_out;
    logic [12:0] stack_top_in, pc_out;
    logic mem_we_out, stack_pop_out, pc_load_out, irq_ack_out, zero_flag_out, master_interrupt_enable_out, busy_out;
    int failures, checked;
    return_or_rotate_exec dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .exec_valid_in(exec_valid_in),
        .exec_op_in(exec_op_in), .mem_addr_in(mem_addr_in), .literal_in(literal_in), .mem_rdata_in(mem_rdata_in),
        .stack_top_in(stack_top_in), .irq_pending_in(irq_pending_in), .mem_we_out(mem_we_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .stack_pop_out(stack_pop_out),
        .pc_load_out(pc_load_out), .pc_out(pc_out), .irq_ack_out(irq_ack_out),
        .working_accumulator_out(working_accumulator_out), .zero_flag_out(zero_flag_out),
        .master_interrupt_enable_out(master_interrupt_enable_out), .busy_out(busy_out));
    task automatic give_verdict();
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input string n, input logic [12:0] s, input logic [12:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // waits for idle under a bound, then holds one request across its taking edge
    task automatic issue(input logic [2:0] op, input logic [7:0] rd, input logic [7:0] lit, input logic [12:0] st);
        for (int n = 0; busy_out !== 1'b0; n++) begin
            if (n > 8) begin
                failures++;
                give_verdict();
            end
            @(posedge clock_in);
            #1;
        end
        @(posedge clock_in);
        exec_valid_in <= 1'b1;
        exec_op_in <= op;
        mem_addr_in <= rd ^ 8'h3c;
        mem_rdata_in <= rd;
        literal_in <= lit;
        stack_top_in <= st;
        @(posedge clock_in);
        exec_valid_in <= 1'b0;
        #1;
    endtask : issue
    task automatic t_lit_or();
        issue(3'h3, 8'h00, 8'ha5, 13'h1abc);
        check("acc", working_accumulator_out, 13'h00a5);
        check("pc", pc_out, 13'h1abc);
        issue(3'h1, 8'h5a, 8'h00, 13'h0000);
        check("wdata", mem_wdata_out, 13'h00ff);
        check("addr", mem_addr_out, 13'h0066);
        check("zero", zero_flag_out, 13'h0000);
        check("busy", busy_out, 13'h0001);
        issue(3'h3, 8'h00, 8'h00, 13'h0011);
        issue(3'h1, 8'h00, 8'h00, 13'h0000);
        check("zero", zero_flag_out, 13'h0001);
    endtask : t_lit_or
    task automatic t_ret_rot();
        issue(3'h2, 8'h00, 8'h77, 13'h0123);
        check("pop", stack_pop_out, 13'h0001);
        check("pc", pc_out, 13'h0123);
        check("zero", zero_flag_out, 13'h0001);
        issue(3'h5, 8'h81, 8'h00, 13'h0000);
        check("wdata", mem_wdata_out, 13'h0003);
        check("we", mem_we_out, 13'h0001);
        check("zero", zero_flag_out, 13'h0001);
    endtask : t_ret_rot
    task automatic t_interrupt_return();
        issue(3'h4, 8'h00, 8'h00, 13'h0456);
        check("emi", master_interrupt_enable_out, 13'h0001);
        check("pc", pc_out, 13'h0456);
        @(posedge clock_in);
        irq_pending_in <= 1'b1;
        issue(3'h4, 8'h00, 8'h00, 13'h0789);
        check("load", pc_load_out, 13'h0000);
        check("busy", busy_out, 13'h0001);
        check("emi", master_interrupt_enable_out, 13'h0001);
        @(posedge clock_in);
        irq_pending_in <= 1'b0;
        #1;
        check("ack", irq_ack_out, 13'h0001);
        check("pop", stack_pop_out, 13'h0000);
        check("pc", pc_out, IRQ_VECTOR_DEFAULT);
        check("emi", master_interrupt_enable_out, 13'h0000);
    endtask : t_interrupt_return
    // free-running clock at 100 ns
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    // reset for 8 cycles, then the scenarios
    initial begin
        {resetn_in, exec_valid_in, irq_pending_in, exec_op_in, mem_addr_in, literal_in, mem_rdata_in} = '0;
        stack_top_in = '0;
        failures = 0;
        checked = 0;
        repeat (8) @(posedge clock_in);
        resetn_in <= 1'b1;
        t_lit_or();
        t_ret_rot();
        t_interrupt_return();
        give_verdict();
    end
endmodule : testbench
